// File: hdl/stream_port_pkg.sv
// Behaviour
// - data field widened to whole bytes
// - padding bits sign or zero extended
// - record aggregated, members padded to widest
// - record with stream member split per member
// - data port never wider than 4096 bits
// - one word per valid-and-ready cycle
// - last marks final transfer; consumer keeps accepting
// - forward mode: data/valid registered, ready combinational
// - reverse mode: only ready registered
// - both mode default, everything registered
// - off mode: no register stage
// - sidebands registered exactly like data
// - packet type: keep, strb, last, user, id, dest
// - zero widths drop user, id, dest
// - without sidebands keep, strb, last remain
// - plain type: only data, valid, ready
// - stream port is one-directional only
package stream_port_pkg;

	// ***************************************************
	// register map
	// ***************************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] XFER_OFS = 4'h8;
	localparam logic [3:0] PKT_OFS = 4'hC;

	localparam int MODE_LSB = 0;
	localparam int ACT_MODE_LSB = 0;
	localparam int FILL_LSB = 4;
	localparam int OUT_VALID_BIT = 8;
	localparam int IN_READY_BIT = 9;
	localparam int PENDING_BIT = 10;

	// ***************************************************
	// register slice modes
	// ***************************************************
	localparam logic [1:0] MODE_FWD = 2'h0;
	localparam logic [1:0] MODE_REV = 2'h1;
	localparam logic [1:0] MODE_BOTH = 2'h2;
	localparam logic [1:0] MODE_OFF = 2'h3;
	localparam logic [1:0] CTRL_RST = MODE_BOTH;

	localparam int MAX_PORT_W = 4096;

	typedef enum logic [3:0] {
		RM_FWD = 4'h1,
		RM_REV = 4'h2,
		RM_BOTH = 4'h4,
		RM_OFF = 4'h8
	} regmode_e;

	function automatic regmode_e decode_mode(input logic [1:0] code);
		case (code)
			MODE_FWD: decode_mode = RM_FWD;
			MODE_REV: decode_mode = RM_REV;
			MODE_OFF: decode_mode = RM_OFF;
			default: decode_mode = RM_BOTH;
		endcase
	endfunction : decode_mode

endpackage : stream_port_pkg

// File: hdl/stream_port_register_slice.sv
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module stream_port_register_slice import stream_port_pkg::*; #(
	parameter int MEMBERS = 1,
	parameter int MEMBER_W = 12,
	parameter bit SIGNED = 1'b0,
	parameter bit PACKET = 1'b1,
	parameter int USER_W = 1,
	parameter int ID_W = 1,
	parameter int DEST_W = 1,
	localparam int SLOT_W = ((MEMBER_W + 7) / 8) * 8,
	localparam int RAW_W = MEMBERS * SLOT_W,
	localparam int TDATA_W = (RAW_W > MAX_PORT_W) ? MAX_PORT_W : RAW_W,
	localparam int KEEP_W = TDATA_W / 8,
	localparam int UW = (USER_W > 0) ? USER_W : 1,
	localparam int IW = (ID_W > 0) ? ID_W : 1,
	localparam int DW = (DEST_W > 0) ? DEST_W : 1
) (
	input wire logic clock,
	input wire logic srst,
	// register bus
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// payload side from the synthesized block
	input wire logic [MEMBERS*MEMBER_W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic in_last,
	input wire logic [KEEP_W-1:0] in_keep,
	input wire logic [KEEP_W-1:0] in_strb,
	input wire logic [UW-1:0] in_user,
	input wire logic [IW-1:0] in_id,
	input wire logic [DW-1:0] in_dest,
	// stream side to the consumer
	output logic [TDATA_W-1:0] m_axis_tdata,
	output logic m_axis_tvalid,
	input wire logic m_axis_tready,
	output logic m_axis_tlast,
	output logic [KEEP_W-1:0] m_axis_tkeep,
	output logic [KEEP_W-1:0] m_axis_tstrb,
	output logic [UW-1:0] m_axis_tuser,
	output logic [IW-1:0] m_axis_tid,
	output logic [DW-1:0] m_axis_tdest
);

	// ***************************************************
	// payload packing
	// ***************************************************
	// one record per port; a record holding a stream member is built
	// as one instance of this block per member
	logic [RAW_W-1:0] packed_w;

	genvar m;
	generate
		for (m = 0; m < MEMBERS; m++) begin : g_member
			logic [MEMBER_W-1:0] field;
			assign field = in_data[m*MEMBER_W +: MEMBER_W];
			if (SLOT_W > MEMBER_W) begin : g_pad
				// pad each member to its byte slot, sign or zero fill
				assign packed_w[m*SLOT_W +: SLOT_W] =
					{{(SLOT_W-MEMBER_W){SIGNED & field[MEMBER_W-1]}}, field};
			end else begin : g_exact
				assign packed_w[m*SLOT_W +: SLOT_W] = field;
			end
		end
	endgenerate

	// ***************************************************
	// sideband gating
	// ***************************************************
	logic [TDATA_W-1:0] src_data;
	logic src_last;
	logic [KEEP_W-1:0] src_keep;
	logic [KEEP_W-1:0] src_strb;
	logic [UW-1:0] src_user;
	logic [IW-1:0] src_id;
	logic [DW-1:0] src_dest;

	assign src_data = packed_w[TDATA_W-1:0];
	assign src_last = PACKET ? in_last : 1'b0;
	assign src_keep = PACKET ? in_keep : '0;
	assign src_strb = PACKET ? in_strb : '0;
	assign src_user = (PACKET && USER_W > 0) ? in_user : '0;
	assign src_id = (PACKET && ID_W > 0) ? in_id : '0;
	assign src_dest = (PACKET && DEST_W > 0) ? in_dest : '0;

	// all sidebands travel as data in one entry
	localparam int ENTRY_W = TDATA_W + 2 * KEEP_W + 1 + UW + IW + DW;
	logic [ENTRY_W-1:0] src_entry;
	logic [ENTRY_W-1:0] out_entry;
	assign src_entry = {src_dest, src_id, src_user, src_last, src_strb, src_keep, src_data};

	// ***************************************************
	// control registers
	// ***************************************************
	logic [1:0] mode_r;
	logic [1:0] act_mode_r;
	logic [31:0] xfer_cnt_r;
	logic [31:0] pkt_cnt_r;
	logic ack_r;
	logic [31:0] readdata_r;
	logic [1:0] fill_r;
	regmode_e act_mode;

	assign act_mode = decode_mode(act_mode_r);

	// ***************************************************
	// two-entry slice buffer
	// ***************************************************
	logic [ENTRY_W-1:0] store_r [2];
	logic wr_idx_r;
	logic rd_idx_r;
	logic bypass;
	logic push;
	logic pop;
	logic fill_empty;
	logic fill_full;
	logic out_fire;
	logic in_fire;

	assign fill_empty = (fill_r == 2'h0);
	assign fill_full = (fill_r == 2'h2);

	// reverse and off modes pass data straight through an empty buffer
	assign bypass = fill_empty && (act_mode == RM_REV || act_mode == RM_OFF);

	always_comb begin
		case (act_mode)
			RM_FWD: in_ready = fill_empty || (fill_r == 2'h1 && m_axis_tready);
			RM_REV: in_ready = !fill_full;
			RM_BOTH: in_ready = !fill_full;
			RM_OFF: in_ready = m_axis_tready;
			default: in_ready = !fill_full;
		endcase
	end

	assign in_fire = in_valid && in_ready;
	assign push = in_fire && !(bypass && m_axis_tready);
	assign pop = !fill_empty && m_axis_tready;

	assign m_axis_tvalid = bypass ? in_valid : !fill_empty;
	assign out_entry = bypass ? src_entry : store_r[rd_idx_r];
	assign out_fire = m_axis_tvalid && m_axis_tready;

	assign {m_axis_tdest, m_axis_tid, m_axis_tuser, m_axis_tlast,
		m_axis_tstrb, m_axis_tkeep, m_axis_tdata} = out_entry;

	// stored entries stay put until taken, so output holds while stalled
	always_ff @(posedge clock) begin
		if (push) begin
			store_r[wr_idx_r] <= src_entry;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wr_idx_r <= 1'b0;
			rd_idx_r <= 1'b0;
		end else begin
			if (push) begin
				wr_idx_r <= !wr_idx_r;
			end
			if (pop) begin
				rd_idx_r <= !rd_idx_r;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			fill_r <= 2'h0;
		end else begin
			case ({push, pop})
				2'b10: fill_r <= fill_r + 2'h1;
				2'b01: fill_r <= fill_r - 2'h1;
				default: fill_r <= fill_r;
			endcase
		end
	end

	// ***************************************************
	// mode selection
	// ***************************************************
	// a new mode takes hold only once the buffer has drained and in_valid is low
	always_ff @(posedge clock) begin
		if (srst) begin
			act_mode_r <= CTRL_RST;
		end else if (fill_empty && !in_valid) begin
			act_mode_r <= mode_r;
		end
	end

	// ***************************************************
	// transfer counters
	// ***************************************************
	logic bus_wr;
	logic bus_rd;
	assign bus_wr = avs_write && !ack_r;
	assign bus_rd = avs_read && !ack_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			xfer_cnt_r <= 32'h0;
			pkt_cnt_r <= 32'h0;
		end else if (bus_wr && avs_address == XFER_OFS) begin
			xfer_cnt_r <= 32'h0;
			pkt_cnt_r <= 32'h0;
		end else if (out_fire) begin
			xfer_cnt_r <= xfer_cnt_r + 32'h1;
			if (m_axis_tlast) begin
				pkt_cnt_r <= pkt_cnt_r + 32'h1;
			end
		end
	end

	// ***************************************************
	// register bus slave
	// ***************************************************
	// every access takes one wait state; ack_r marks the answering cycle
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign avs_readdata = readdata_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			mode_r <= CTRL_RST;
		end else if (bus_wr && avs_address == CTRL_OFS && avs_byteenable[0]) begin
			mode_r <= avs_writedata[MODE_LSB +: 2];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			readdata_r <= 32'h0;
		end else if (bus_rd) begin
			readdata_r <= 32'h0;
			case (avs_address)
				CTRL_OFS: readdata_r[MODE_LSB +: 2] <= mode_r;
				STATUS_OFS: begin
					readdata_r[ACT_MODE_LSB +: 2] <= act_mode_r;
					readdata_r[FILL_LSB +: 2] <= fill_r;
					readdata_r[OUT_VALID_BIT] <= m_axis_tvalid;
					readdata_r[IN_READY_BIT] <= in_ready;
					readdata_r[PENDING_BIT] <= (mode_r != act_mode_r);
				end
				XFER_OFS: readdata_r <= xfer_cnt_r;
				PKT_OFS: readdata_r <= pkt_cnt_r;
				default: readdata_r <= 32'h0;
			endcase
		end
	end

endmodule : stream_port_register_slice

// File: tb/stream_port_checks_asserts.sv
`timescale 1ns/1ps
module stream_port_checks #(
	parameter int MEMBER_W = 12,
	parameter bit SIGNED = 1'b0,
	parameter int TDATA_W = 16,
	parameter int KEEP_W = 2
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [MEMBER_W-1:0] in_data,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic in_last,
	input wire logic [KEEP_W-1:0] in_keep,
	input wire logic [KEEP_W-1:0] in_strb,
	input wire logic [TDATA_W-1:0] m_axis_tdata,
	input wire logic m_axis_tvalid,
	input wire logic m_axis_tready,
	input wire logic m_axis_tlast,
	input wire logic [KEEP_W-1:0] m_axis_tkeep,
	input wire logic [KEEP_W-1:0] m_axis_tstrb
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	wire take = in_valid && in_ready && !m_axis_tvalid;
	property p_hold;
		m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid && $stable(m_axis_tdata);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed while stalled");
	property p_pad;
		m_axis_tvalid |-> m_axis_tdata[TDATA_W-1:MEMBER_W] ==
			{(TDATA_W-MEMBER_W){SIGNED & m_axis_tdata[MEMBER_W-1]}};
	endproperty
	a_pad: assert property (p_pad) else $error("bad padding bits");
	property p_lat;
		take |=> m_axis_tvalid;
	endproperty
	a_lat: assert property (p_lat) else $error("taken word not shown");
	property p_data;
		take |=> m_axis_tdata[MEMBER_W-1:0] == $past(in_data);
	endproperty
	a_data: assert property (p_data) else $error("payload lost");
	property p_side;
		take |=> m_axis_tlast == $past(in_last) && m_axis_tkeep == $past(in_keep);
	endproperty
	a_side: assert property (p_side) else $error("sideband not aligned");
	property p_strb;
		take |=> m_axis_tstrb == $past(in_strb);
	endproperty
	a_strb: assert property (p_strb) else $error("strobe not aligned");
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("more than one wait state");
	property p_idle;
		!(avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("wait without request");
	c_stall: cover property (m_axis_tvalid && !m_axis_tready);
	c_last: cover property (m_axis_tvalid && m_axis_tready && m_axis_tlast);
	c_full: cover property (in_valid && !in_ready);
endmodule : stream_port_checks
bind stream_port_register_slice stream_port_checks #(.MEMBER_W(MEMBER_W), .SIGNED(SIGNED),
	.TDATA_W(TDATA_W), .KEEP_W(KEEP_W)) i_chk (.clock(clock), .srst(srst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last),
	.in_keep(in_keep), .in_strb(in_strb), .m_axis_tdata(m_axis_tdata),
	.m_axis_tvalid(m_axis_tvalid), .m_axis_tready(m_axis_tready),
	.m_axis_tlast(m_axis_tlast), .m_axis_tkeep(m_axis_tkeep), .m_axis_tstrb(m_axis_tstrb));

// File: tb/stream_consumer.sv
`timescale 1ns/1ps
module stream_consumer (
	input wire logic clock,
	input wire logic srst,
	input wire logic slow,
	output logic tready
);
	// takes every word, last included; stalls at random when slow
	always @(posedge clock) begin
		if (srst)
			tready <= 1'b0;
		else
			tready <= !slow || $urandom_range(0, 1);
	end
endmodule : stream_consumer

// File: tb/stream_port_register_slice_test.sv
`timescale 1ns/1ps
module stream_port_register_slice_test;
	import stream_port_pkg::*;
	localparam bit SGN = 1'b1;
	logic clock = 0, srst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, slow = 0;
	logic [3:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic [11:0] in_data = 0;
	logic in_valid = 0, in_ready, in_last = 0, in_user = 0, in_id = 0, in_dest = 0;
	logic [1:0] in_keep = 0, in_strb = 0, m_axis_tkeep, m_axis_tstrb;
	logic [15:0] m_axis_tdata;
	logic m_axis_tvalid, m_axis_tready, m_axis_tlast, m_axis_tuser, m_axis_tid, m_axis_tdest;
	logic [23:0] q[$];
	int n_errors = 0, n_checks = 0, n_words, n_pkts, m;
	// ***************************************************
	// clock, design, consumer
	// ***************************************************
	initial forever #12.5 clock = ~clock;
	stream_port_register_slice #(.SIGNED(SGN)) i_dut (.clock, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
		.in_data, .in_valid, .in_ready, .in_last, .in_keep, .in_strb, .in_user, .in_id, .in_dest,
		.m_axis_tdata, .m_axis_tvalid, .m_axis_tready, .m_axis_tlast, .m_axis_tkeep,
		.m_axis_tstrb, .m_axis_tuser, .m_axis_tid, .m_axis_tdest);
	stream_consumer i_cons (.clock, .srst, .slow, .tready(m_axis_tready));
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	function logic [15:0] pad(input logic [11:0] d);
		pad = {{4{SGN & d[11]}}, d};
	endfunction : pad
	task av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int i;
		i = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		@(negedge clock);
		while (avs_waitrequest !== 1'b0 && i < 20) begin
			i++;
			@(negedge clock);
		end
		@(posedge clock);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (i == 20) n_errors++;
		@(posedge clock);
	endtask : av
	task send(input logic chk, input logic exp_byp);
		logic [11:0] d;
		logic [7:0] s;
		int i;
		i = 0;
		d = $urandom;
		s = $urandom;
		if ($urandom_range(0, 5) == 0) d = 12'h800;
		{in_dest, in_id, in_user, in_strb, in_keep, in_last} <= s;
		in_data <= d;
		in_valid <= 1;
		q.push_back({pad(d), s});
		n_words++;
		n_pkts += s[0];
		@(negedge clock);
		if (chk) check("bypass", m_axis_tvalid, exp_byp);
		while (in_ready !== 1'b1 && i < 50) begin
			i++;
			@(negedge clock);
		end
		@(posedge clock);
	endtask : send
	always @(posedge clock) begin
		if (!srst && m_axis_tvalid && m_axis_tready) begin
			check("word", {m_axis_tdata, m_axis_tdest, m_axis_tid, m_axis_tuser, m_axis_tstrb,
				m_axis_tkeep, m_axis_tlast}, q.size() ? q.pop_front() : 'x);
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		final_report();
	end
	initial begin
		int i;
		void'($urandom(81799));
		repeat (3) @(posedge clock);
		srst <= 0;
		av(0, CTRL_OFS, 0);
		check("ctrl", rd, 32'(CTRL_RST));
		av(0, 4'h2, 0);
		check("hole", rd, 0);
		for (m = 0; m < 4; m++) begin
			av(1, CTRL_OFS, m);
			av(1, XFER_OFS, 0);
			n_words = 0;
			n_pkts = 0;
			av(0, STATUS_OFS, 0);
			check("mode", rd[1:0], m[1:0]);
			send(1, m[0]);
			slow <= 1;
			repeat (24) send(0, 0);
			in_valid <= 0;
			slow <= 0;
			i = 0;
			while (q.size() != 0 && i < 100) begin
				i++;
				@(posedge clock);
			end
			av(0, XFER_OFS, 0);
			check("words", rd, n_words);
			av(0, PKT_OFS, 0);
			check("pkts", rd, n_pkts);
		end
		final_report();
	end
endmodule : stream_port_register_slice_test
